// ===== svcr_receiver.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - A command is START, address byte, one data byte, STOP, and only that frame is acted on.
// - The address matches only when bits 6 to 4 are 110, bit 3 being ignored.
// - Address bit 2 selects the core-1 rail, ignored in combined mode.
// - Address bit 1 selects core-0 in separate mode or the unified rail in combined mode.
// - Address bit 0 selects the bridge rail, and several selects may be set together.
// - A hint of 0 asks for pulse-skipping after boot and drops any option offset.
// - A hint of 1 asks for forced continuous switching after boot and restores the option offset.
// - In combined mode the hint of 0 gives single-phase and 1 gives 2-phase operation.
// - Data bits 6 to 0 are the voltage code for every selected rail.
// - START is data falling while clock is high, taken in any state, and begins every command.
// - STOP is data rising while clock is high and ends every operation.
// - Data is sampled while clock is high, one bit per pulse, changing only when clock is low.
// - On the ninth clock the device pulls data low, for the address only on match outside programming mode.
module svcr_receiver
	import svcr_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic vid_bus_clock,
	input wire logic vid_bus_data_in,
	output logic vid_bus_data_out,
	output logic vid_bus_data_oe,
	input wire logic first_ground_sense,
	input wire logic second_ground_sense,
	input wire logic programming_mode,
	input wire logic boot_done,
	input wire logic option_offset_enable,
	output logic [6:0] core1_voltage_code,
	output logic [6:0] core0_voltage_code,
	output logic [6:0] bridge_voltage_code,
	output logic [2:0] power_save_hint_n,
	output logic [2:0] pulse_skip_mode,
	output logic [2:0] offset_enable,
	output logic combined_mode,
	output logic two_phase,
	output logic command_done
);
	// Strap and mode pins pass two flops like the bus pins
	typedef struct packed {
		logic gnd1;
		logic gnd2;
		logic prog;
		logic boot;
		logic opt;
	} svcr_straps_s;

	typedef struct packed {
		svcr_state_e st;
		svcr_lines_s prev;
		svcr_straps_s straps_meta;
		svcr_straps_s straps;
		logic [7:0] shift;
		logic [3:0] count;
		logic [2:0] sel;
		logic oe;
		logic done;
		logic comb;
		svcr_rail_s [SVCR_RAILS-1:0] rail;
		svcr_rail_s pend;
		logic pend_valid;
		logic [2:0] skip;
		logic [2:0] offs;
		logic two_ph;
	} svcr_state_s;

	svcr_state_s s_r;
	svcr_state_s s_nxt;
	svcr_lines_s lines;
	svcr_lines_s pins;

	assign pins = '{scl: vid_bus_clock, sda: vid_bus_data_in};

	svcr_sync u_sync (
		.clock(clock),
		.rst(rst),
		.async_in(pins),
		.sync_out(lines)
	);

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic addr_match;
	logic [2:0] byte_sel;

	assign scl_rise = lines.scl && !s_r.prev.scl;
	assign scl_fall = !lines.scl && s_r.prev.scl;
	assign start_cond = lines.scl && s_r.prev.scl && s_r.prev.sda && !lines.sda;
	assign stop_cond = lines.scl && s_r.prev.scl && !s_r.prev.sda && lines.sda;
	// Address bit n sits at byte bit n+1; bit 3 and the direction bit play no part
	assign addr_match = (s_r.shift[SVCR_ADDR_CODE_HI+1:SVCR_ADDR_CODE_LO+1] == SVCR_ADDR_CODE)
		&& !s_r.straps.prog;
	always_comb begin
		byte_sel = '0;
		byte_sel[SVCR_SEL_CORE1] = s_r.shift[SVCR_SEL_CORE1+1] && !s_r.comb;
		byte_sel[SVCR_SEL_CORE0] = s_r.shift[SVCR_SEL_CORE0+1];
		byte_sel[SVCR_SEL_BRIDGE] = s_r.shift[SVCR_SEL_BRIDGE+1];
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.prev = lines;
		s_nxt.done = 1'b0;
		s_nxt.straps_meta = '{gnd1: first_ground_sense, gnd2: second_ground_sense,
			prog: programming_mode, boot: boot_done, opt: option_offset_enable};
		s_nxt.straps = s_r.straps_meta;
		s_nxt.comb = s_r.straps.gnd1 || s_r.straps.gnd2;
		if (scl_rise) begin
			s_nxt.shift = {s_r.shift[6:0], lines.sda};
		end
		unique case (s_r.st)
			SVCR_IDLE: begin
				s_nxt.oe = 1'b0;
			end
			SVCR_ADDR, SVCR_DATA: begin
				if (scl_rise) begin
					s_nxt.count = s_r.count + 4'h1;
				end
				if (scl_fall && s_r.count == SVCR_BITS_PER_BYTE) begin
					s_nxt.count = '0;
					if (s_r.st == SVCR_DATA) begin
						s_nxt.pend = s_r.shift;
						s_nxt.oe = 1'b1;
						s_nxt.st = SVCR_DATA_ACK;
					end else if (addr_match) begin
						s_nxt.sel = byte_sel;
						s_nxt.oe = 1'b1;
						s_nxt.st = SVCR_ADDR_ACK;
					end else begin
						s_nxt.st = SVCR_IGNORE;
					end
				end
			end
			SVCR_ADDR_ACK, SVCR_DATA_ACK: begin
				if (scl_fall) begin
					s_nxt.oe = 1'b0;
					if (s_r.st == SVCR_ADDR_ACK) begin
						s_nxt.st = SVCR_DATA;
					end else begin
						s_nxt.pend_valid = 1'b1;
						s_nxt.st = SVCR_WAIT_STOP;
					end
				end
			end
			SVCR_WAIT_STOP, SVCR_IGNORE: begin
				s_nxt.oe = 1'b0;
			end
		endcase
		// A finished further clock pulse breaks the frame; the rise ahead of a STOP does not
		if (s_r.st == SVCR_WAIT_STOP && scl_fall) begin
			s_nxt.pend_valid = 1'b0;
			s_nxt.st = SVCR_IGNORE;
		end
		if (stop_cond) begin
			s_nxt.oe = 1'b0;
			s_nxt.st = SVCR_IDLE;
			s_nxt.count = '0;
			s_nxt.pend_valid = 1'b0;
			if (s_r.st == SVCR_WAIT_STOP && s_r.pend_valid) begin
				s_nxt.done = 1'b1;
				for (int i = 0; i < SVCR_RAILS; i++) begin
					if (s_r.sel[i]) begin
						s_nxt.rail[i] = s_r.pend;
					end
				end
			end
		end
		if (start_cond) begin
			s_nxt.st = SVCR_ADDR;
			s_nxt.count = '0;
			s_nxt.oe = 1'b0;
			s_nxt.pend_valid = 1'b0;
		end
		for (int i = 0; i < SVCR_RAILS; i++) begin
			s_nxt.skip[i] = s_r.straps.boot && !s_r.rail[i].hint_n;
			s_nxt.offs[i] = s_r.straps.opt && s_r.rail[i].hint_n;
		end
		s_nxt.two_ph = !s_r.comb || s_r.rail[SVCR_SEL_CORE0].hint_n;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_r <= '0;
			s_r.st <= SVCR_IDLE;
			s_r.prev <= '1;
			for (int i = 0; i < SVCR_RAILS; i++) begin
				s_r.rail[i] <= '{hint_n: SVCR_HINT_RESET, code: SVCR_CODE_RESET};
			end
			s_r.two_ph <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign vid_bus_data_out = 1'b0;
	assign vid_bus_data_oe = s_r.oe;
	assign core1_voltage_code = s_r.rail[SVCR_SEL_CORE1].code;
	assign core0_voltage_code = s_r.rail[SVCR_SEL_CORE0].code;
	assign bridge_voltage_code = s_r.rail[SVCR_SEL_BRIDGE].code;
	always_comb begin
		for (int i = 0; i < SVCR_RAILS; i++) begin
			power_save_hint_n[i] = s_r.rail[i].hint_n;
		end
	end
	assign pulse_skip_mode = s_r.skip;
	assign offset_enable = s_r.offs;
	assign combined_mode = s_r.comb;
	assign two_phase = s_r.two_ph;
	assign command_done = s_r.done;

	ack_after_byte_a: assert property (@(posedge clock) disable iff (rst)
		(s_r.st == SVCR_DATA && scl_fall && s_r.count == SVCR_BITS_PER_BYTE) |=> vid_bus_data_oe)
		else $error("no acknowledge after data byte");
	no_ack_mismatch_a: assert property (@(posedge clock) disable iff (rst)
		(s_r.st == SVCR_IGNORE) |-> !vid_bus_data_oe)
		else $error("acknowledge while ignoring");
	update_on_stop_a: assert property (@(posedge clock) disable iff (rst)
		!(s_r.st == SVCR_WAIT_STOP && stop_cond) |=> $stable(core0_voltage_code))
		else $error("rail changed outside a stop");
	unselected_keep_a: assert property (@(posedge clock) disable iff (rst)
		(stop_cond && !s_r.sel[SVCR_SEL_BRIDGE]) |=> $stable(bridge_voltage_code))
		else $error("unselected rail changed");
	start_enters_addr_a: assert property (@(posedge clock) disable iff (rst)
		start_cond |=> (s_r.st == SVCR_ADDR && s_r.count == 4'h0))
		else $error("start not taken");
	stop_idles_a: assert property (@(posedge clock) disable iff (rst)
		(stop_cond && !start_cond) |=> (s_r.st == SVCR_IDLE && !vid_bus_data_oe))
		else $error("stop not taken");
	core1_comb_a: assert property (@(posedge clock) disable iff (rst)
		(s_r.st == SVCR_ADDR_ACK && s_r.comb && $past(s_r.comb)) |-> !s_r.sel[SVCR_SEL_CORE1])
		else $error("core1 selected in combined mode");
	phase_hint_a: assert property (@(posedge clock) disable iff (rst)
		(combined_mode && !power_save_hint_n[SVCR_SEL_CORE0]) |=> !two_phase)
		else $error("combined mode not single phase");
	skip_mode_a: assert property (@(posedge clock) disable iff (rst)
		(s_r.straps.boot && !power_save_hint_n[SVCR_SEL_BRIDGE]) |=> pulse_skip_mode[SVCR_SEL_BRIDGE])
		else $error("pulse skipping not entered");
	offset_restore_a: assert property (@(posedge clock) disable iff (rst)
		(s_r.straps.opt && power_save_hint_n[SVCR_SEL_BRIDGE]) |=> offset_enable[SVCR_SEL_BRIDGE])
		else $error("offset not restored");
	cover_command_c: cover property (@(posedge clock) command_done);
	cover_mismatch_c: cover property (@(posedge clock) s_r.st == SVCR_IGNORE);
	cover_comb_c: cover property (@(posedge clock) command_done && combined_mode);
endmodule : svcr_receiver
`default_nettype wire

// ===== svcr_pkg.sv
package svcr_pkg;
	localparam int SVCR_SYNC_STAGES = 2;
	localparam logic [2:0] SVCR_ADDR_CODE = 3'h6;
	localparam int SVCR_ADDR_CODE_HI = 6;
	localparam int SVCR_ADDR_CODE_LO = 4;
	localparam int SVCR_SEL_CORE1 = 2;
	localparam int SVCR_SEL_CORE0 = 1;
	localparam int SVCR_SEL_BRIDGE = 0;
	localparam int SVCR_HINT_BIT = 7;
	localparam logic [3:0] SVCR_BITS_PER_BYTE = 4'h8;
	localparam int SVCR_RAILS = 3;
	localparam logic [6:0] SVCR_CODE_RESET = 7'h00;
	localparam logic SVCR_HINT_RESET = 1'h1;

	typedef enum logic [2:0] {
		SVCR_IDLE,
		SVCR_ADDR,
		SVCR_ADDR_ACK,
		SVCR_DATA,
		SVCR_DATA_ACK,
		SVCR_WAIT_STOP,
		SVCR_IGNORE
	} svcr_state_e;

	typedef struct packed {
		logic hint_n;
		logic [6:0] code;
	} svcr_rail_s;

	typedef struct packed {
		logic scl;
		logic sda;
	} svcr_lines_s;
endpackage : svcr_pkg

// ===== svcr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module svcr_sync
	import svcr_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire svcr_lines_s async_in,
	output svcr_lines_s sync_out
);
	typedef struct packed {
		svcr_lines_s meta;
		svcr_lines_s stable;
	} svcr_sync_s;

	svcr_sync_s state_r;
	svcr_sync_s state_nxt;

	always_comb begin
		state_nxt.meta = async_in;
		state_nxt.stable = state_r.meta;
	end

	// Lines idle high, so reset to the bus-free level
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= '1;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign sync_out = state_r.stable;
endmodule : svcr_sync
`default_nettype wire

// ===== svcr_master.sv
`timescale 1ns/1ps
`default_nettype none
module svcr_master
	import svcr_pkg::*;
(
	input wire logic dev_oe,
	output logic bus_clock,
	output logic bus_data
);
	logic drive;
	// Pull-up wins wherever nobody pulls the line low
	assign bus_data = drive & ~dev_oe;
	initial begin
		bus_clock = 1'h1;
		drive = 1'h1;
	end
	task automatic pulse(output logic seen);
		#20 bus_clock = 1'h1;
		#20 seen = bus_data;
		#20 bus_clock = 1'h0;
		#20;
	endtask : pulse
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			drive = b[i];
			pulse(s);
		end
		drive = 1'h1;
		pulse(ack);
	endtask : put_byte
	task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic whole,
		output logic [1:0] acks);
		acks = 2'h3;
		#20 drive = 1'h0;
		#40 bus_clock = 1'h0;
		#20;
		put_byte(a, acks[1]);
		if (whole) put_byte(d, acks[0]);
		#20 drive = 1'h0;
		#20 bus_clock = 1'h1;
		#40 drive = 1'h1;
		#80;
	endtask : frame
endmodule : svcr_master
`default_nettype wire

// ===== svcr_receiver_test.sv
`timescale 1ns/1ps
`default_nettype none
module svcr_receiver_test
	import svcr_pkg::*;
;
	logic clock = 1'h0;
	logic rst = 1'h1;
	logic bus_clock, bus_data, data_out, data_oe, gs1, gs2, prog, boot, opt, comb, two, done;
	logic [6:0] c1, c0, cb;
	logic [2:0] hint, skip, offs;
	logic [7:0] a, d;
	logic [31:0] r;
	logic [1:0] acks;
	logic whole, aw;
	logic [30:0] seen_v;
	logic [30:0] exp_q[$];
	svcr_rail_s rail [3];
	int failures = 0;
	int n_tests = 0;
	int seed = 32'h2abb4022;
	assign seen_v = {c1, c0, cb, hint, skip, offs, two};
	initial begin
		forever #5 clock = ~clock;
	end
	svcr_master svcr_master_i (.dev_oe(data_oe), .bus_clock(bus_clock), .bus_data(bus_data));
	svcr_receiver svcr_receiver_i (.clock(clock), .rst(rst), .vid_bus_clock(bus_clock),
		.vid_bus_data_in(bus_data), .vid_bus_data_out(data_out), .vid_bus_data_oe(data_oe),
		.first_ground_sense(gs1), .second_ground_sense(gs2), .programming_mode(prog),
		.boot_done(boot), .option_offset_enable(opt), .core1_voltage_code(c1),
		.core0_voltage_code(c0), .bridge_voltage_code(cb), .power_save_hint_n(hint),
		.pulse_skip_mode(skip), .offset_enable(offs), .combined_mode(comb),
		.two_phase(two), .command_done(done));
	task automatic check(input logic [30:0] seen, input logic [30:0] want);
		n_tests++;
		if (seen !== want) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	function automatic logic [30:0] want_v();
		logic [2:0] h;
		h = {rail[2].hint_n, rail[1].hint_n, rail[0].hint_n};
		return {rail[2].code, rail[1].code, rail[0].code, h, {3{boot}} & ~h, {3{opt}} & h,
			~(gs1 | gs2) | h[1]};
	endfunction : want_v
	// Shaping outputs follow the rails one clock later, so look a cycle after the pulse
	always @(negedge clock) begin
		if (done === 1'h1) begin
			@(negedge clock);
			check({30'h0, comb}, {30'h0, gs1 | gs2});
			if (exp_q.size() == 0)
				check(31'h0, 31'h1);
			else
				check(seen_v, exp_q.pop_front());
		end
	end
	initial begin
		#200000;
		failures++;
		complete_run();
	end
	initial begin
		{gs1, gs2, prog, boot, opt} = 5'h0;
		for (int k = 0; k < 3; k++)
			rail[k] = {SVCR_HINT_RESET, SVCR_CODE_RESET};
		repeat (2) @(posedge clock);
		@(negedge clock) rst = 1'h0;
		repeat (4) @(negedge clock);
		check(seen_v, want_v());
		check({29'h0, data_out, data_oe}, 31'h0);
		for (int i = 0; i < 40; i++) begin
			a = 8'($random(seed));
			d = 8'($random(seed));
			r = $random(seed);
			if (r[0])
				a[7:5] = 3'h6;
			a[0] = 1'h1;
			@(negedge clock) {gs1, gs2, prog, boot, opt} = {r[1], r[2], r[3] & r[4], r[5], r[6]};
			whole = r[7] | r[8];
			aw = (a[7:5] == 3'h6) && !prog;
			if (aw && whole) begin
				if (a[3] && !(gs1 | gs2))
					rail[2] = d;
				if (a[2])
					rail[1] = d;
				if (a[1])
					rail[0] = d;
				exp_q.push_back(want_v());
			end
			svcr_master_i.frame(a, d, whole, acks);
			check({29'h0, acks}, {29'h0, ~aw, ~(aw & whole)});
			$display("test %0d ended", i);
		end
		for (int k = 0; k < 100 && exp_q.size() != 0; k++)
			@(posedge clock);
		check(31'(exp_q.size()), 31'h0);
		complete_run();
	end
endmodule : svcr_receiver_test
`default_nettype wire
